// ---- core/mudl_cfg.svh ----
`ifndef MUDL_CFG_SVH
`define MUDL_CFG_SVH
// Delay code limits and guard band scaling.
`define MUDL_CODE_W 9
`define MUDL_CODE_MIN 9'h000
`define MUDL_CODE_MAX 9'h1b0
`define MUDL_CODE_RST 9'h0d8
`define MUDL_GUARD_SHIFT 3
`define MUDL_STEP_PS 2
`define MUDL_SPAN_PS 864
// Phase scale: 16 means a half cycle.
`define MUDL_PHASE_W 5
`define MUDL_PHASE_HALF 5'h10
`define MUDL_LOSE_ERR 5'h04
`define MUDL_KEEP_ERR 5'h03
`define MUDL_ONE 9'h001
`endif

// ---- core/mudl_pkg.sv ----
package mudl_pkg;
  typedef enum logic [2:0] {
    MUDL_IDLE,
    MUDL_SEARCH,
    MUDL_TRACK,
    MUDL_FAILED
  } mudl_state_e;
endpackage : mudl_pkg

// ---- core/mudl_phase_loop.sv ----
`include "mudl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mudl_phase_loop
  import mudl_pkg::*;
#(
  parameter int CODE_W = `MUDL_CODE_W,
  parameter int PHASE_W = `MUDL_PHASE_W
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic loop_enable,
  input wire logic [CODE_W-1:0] initial_code,
  input wire logic [PHASE_W-1:0] target_phase,
  input wire logic slope_negative,
  input wire logic [4:0] guard_band,
  input wire logic restart_on_loss,
  input wire logic retry_on_fail,
  input wire logic [PHASE_W-1:0] measured_phase,
  input wire logic phase_valid,
  output logic [CODE_W-1:0] phase_delay_code,
  output logic phase_loop_locked,
  output logic phase_loop_lost,
  output logic tracking,
  output logic search_failed
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_ff;
  logic rst_sync_ff;

  // Two stages so reset leaves every flop on the same edge.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ****************************************
  // Loop state
  // ****************************************
  mudl_state_e state_ff, nxt_state;
  logic [CODE_W-1:0] code_ff, nxt_code;
  logic [CODE_W-1:0] base_ff, nxt_base;
  logic [CODE_W-1:0] dist_ff, nxt_dist;
  logic up_ff, nxt_up;
  logic [PHASE_W-1:0] prev_ff, nxt_prev;
  logic prev_ok_ff, nxt_prev_ok;
  logic lock_ff, nxt_lock;
  logic lost_ff, nxt_lost;
  logic fail_ff, nxt_fail;

  logic [CODE_W:0] guard_codes;
  logic [CODE_W:0] lo_lim;
  logic [CODE_W:0] hi_lim;
  logic [PHASE_W-1:0] err;
  logic err_neg;
  logic slope_ok;
  logic [CODE_W:0] cand;

  // Guard band in codes, kept at both ends alike.
  assign guard_codes = (CODE_W+1)'(guard_band) << `MUDL_GUARD_SHIFT;
  assign lo_lim = guard_codes;
  assign hi_lim = (guard_codes > (CODE_W+1)'(`MUDL_CODE_MAX)) ? (CODE_W+1)'(0)
                  : (CODE_W+1)'(`MUDL_CODE_MAX) - guard_codes;
  // Phase wraps at 32 (360 degrees), so the error is taken modulo the scale.
  assign err = measured_phase - target_phase;
  assign err_neg = err[PHASE_W-1];
  // Slope is judged from the last sample and the direction of the last step.
  assign slope_ok = prev_ok_ff && ((measured_phase != prev_ff) &&
                    (((measured_phase - prev_ff) >= `MUDL_PHASE_HALF) == (up_ff ^ !slope_negative)) );

  // Next-state logic for the search and track machine.
  always_comb begin
    nxt_state = state_ff;
    nxt_code = code_ff;
    nxt_base = base_ff;
    nxt_dist = dist_ff;
    nxt_up = up_ff;
    nxt_prev = prev_ff;
    nxt_prev_ok = prev_ok_ff;
    nxt_lock = lock_ff;
    nxt_lost = lost_ff;
    nxt_fail = fail_ff;
    cand = '0;
    unique case (state_ff)
      MUDL_IDLE: begin
        if (loop_enable) begin
          nxt_state = MUDL_SEARCH;
          nxt_code = (initial_code > `MUDL_CODE_MAX) ? `MUDL_CODE_MAX : initial_code;
          nxt_base = nxt_code;
          nxt_dist = '0;
          nxt_up = 1'b0;
          nxt_prev_ok = 1'b0;
          nxt_fail = 1'b0;
          nxt_lost = 1'b0;
        end
      end
      MUDL_SEARCH: begin
        if (phase_valid) begin
          nxt_prev = measured_phase;
          nxt_prev_ok = 1'b1;
          if (err == '0 && slope_ok) begin
            nxt_state = MUDL_TRACK;
            nxt_lock = 1'b1;
          end else begin
            // Alternate up then down, widening each time up is taken.
            nxt_up = !up_ff;
            nxt_dist = dist_ff + (up_ff ? CODE_W'(0) : `MUDL_ONE);
            if (nxt_up) begin
              cand = (CODE_W+1)'(base_ff) + (CODE_W+1)'(nxt_dist);
              if (cand > hi_lim) begin
                nxt_up = 1'b0; // Guard reached above, sweep below only.
                cand = ((CODE_W+1)'(base_ff) >= (CODE_W+1)'(nxt_dist)) ?
                       (CODE_W+1)'(base_ff) - (CODE_W+1)'(nxt_dist) : '0;
              end
            end else begin
              cand = ((CODE_W+1)'(base_ff) >= (CODE_W+1)'(nxt_dist)) ?
                     (CODE_W+1)'(base_ff) - (CODE_W+1)'(nxt_dist) : '0;
              if (cand < lo_lim) begin
                nxt_up = 1'b1; // Guard reached below, code stays at base plus the same distance.
                cand = (CODE_W+1)'(base_ff) + (CODE_W+1)'(nxt_dist);
              end
            end
            // Hitting either end of the line ends the search as failed.
            if (cand >= (CODE_W+1)'(`MUDL_CODE_MAX) || cand == '0) begin
              nxt_code = (cand > (CODE_W+1)'(`MUDL_CODE_MAX)) ? `MUDL_CODE_MAX : cand[CODE_W-1:0];
              nxt_fail = 1'b1;
              nxt_state = retry_on_fail ? MUDL_IDLE : MUDL_FAILED;
            end else begin
              nxt_code = cand[CODE_W-1:0];
            end
          end
        end
      end
      MUDL_TRACK: begin
        if (phase_valid) begin
          // Nudge one step toward the target, saturated at the ends.
          // A phase above target on a falling slope needs more delay, and vice versa.
          if (err != '0) begin
            if (err_neg != slope_negative) begin
              if (code_ff < `MUDL_CODE_MAX) nxt_code = code_ff + `MUDL_ONE;
              else begin
                // A pinned code cannot follow the drift, so lock is given up with it unless the error is 3 or less.
                nxt_lost = lock_ff;
                nxt_lock = 1'b0;
              end
            end else begin
              if (code_ff > `MUDL_CODE_MIN) nxt_code = code_ff - `MUDL_ONE;
              else begin
                nxt_lost = lock_ff;
                nxt_lock = 1'b0;
              end
            end
          end
          if ((err_neg ? -err : err) > `MUDL_LOSE_ERR) begin
            nxt_lock = 1'b0;
            if (lock_ff) nxt_lost = 1'b1;
          end else if ((err_neg ? -err : err) <= `MUDL_KEEP_ERR) begin
            nxt_lock = 1'b1;
            nxt_lost = 1'b0;
          end
          if (nxt_lost && !lost_ff && restart_on_loss) begin
            nxt_state = MUDL_IDLE;
            nxt_lock = 1'b0;
          end
        end
      end
      MUDL_FAILED: begin
        nxt_state = MUDL_FAILED;
      end
      default: nxt_state = MUDL_IDLE;
    endcase
    // Dropping the enable always parks the loop.
    if (!loop_enable) begin
      nxt_state = MUDL_IDLE;
      nxt_lock = 1'b0;
    end
  end

  // Registers of the loop machine.
  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff <= MUDL_IDLE;
      code_ff <= `MUDL_CODE_RST;
      base_ff <= `MUDL_CODE_RST;
      dist_ff <= '0;
      up_ff <= 1'b0;
      prev_ff <= '0;
      prev_ok_ff <= 1'b0;
      lock_ff <= 1'b0;
      lost_ff <= 1'b0;
      fail_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      code_ff <= nxt_code;
      base_ff <= nxt_base;
      dist_ff <= nxt_dist;
      up_ff <= nxt_up;
      prev_ff <= nxt_prev;
      prev_ok_ff <= nxt_prev_ok;
      lock_ff <= nxt_lock;
      lost_ff <= nxt_lost;
      fail_ff <= nxt_fail;
    end
  end

  // The code drives the external tapped line whose output clocks the chip.
  assign phase_delay_code = code_ff;
  assign phase_loop_locked = lock_ff;
  assign phase_loop_lost = lost_ff;
  assign tracking = (state_ff == MUDL_TRACK);
  assign search_failed = fail_ff;

endmodule : mudl_phase_loop
`default_nettype wire

// ---- tb/mudl_phase_loop_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// Checker watching the loop ports only.
module mudl_phase_loop_chk #(
  parameter int CODE_W = 9,
  parameter int PHASE_W = 5
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic loop_enable,
  input wire logic [CODE_W-1:0] initial_code,
  input wire logic [PHASE_W-1:0] target_phase,
  input wire logic slope_negative,
  input wire logic [4:0] guard_band,
  input wire logic restart_on_loss,
  input wire logic retry_on_fail,
  input wire logic [PHASE_W-1:0] measured_phase,
  input wire logic phase_valid,
  input wire logic [CODE_W-1:0] phase_delay_code,
  input wire logic phase_loop_locked,
  input wire logic phase_loop_lost,
  input wire logic tracking,
  input wire logic search_failed
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // A tracking step, and one that lands on the target or far from it.
  sequence s_trk; tracking && phase_valid && loop_enable; endsequence
  sequence s_hit; s_trk ##0 (measured_phase == target_phase); endsequence
  sequence s_far; s_trk ##0 ((measured_phase - target_phase) inside {[5'h05:5'h1b]}); endsequence
  a_code_range: assert property (phase_delay_code <= 9'h1b0) else $error("code out of range");
  a_lock_track: assert property (phase_loop_locked |-> tracking) else $error("lock outside track");
  a_flag_excl: assert property (!(phase_loop_locked && phase_loop_lost)) else $error("lock and lost");
  a_trk_hold: assert property (tracking && !phase_valid && loop_enable |=> $stable(phase_delay_code))
    else $error("code moved without sample");
  a_trk_step: assert property (s_trk |=> (phase_delay_code == $past(phase_delay_code)
    || phase_delay_code == $past(phase_delay_code) + 9'h001
    || phase_delay_code == $past(phase_delay_code) - 9'h001)) else $error("track step too big");
  a_hit_lock: assert property (s_hit |=> phase_loop_locked) else $error("no lock on target");
  a_far_unlock: assert property (s_far |=> !phase_loop_locked) else $error("lock kept on error");
  // The enable must have stood a cycle already, since a fresh start clears the flag by design.
  a_fail_hold: assert property (search_failed && loop_enable && $past(loop_enable) && !retry_on_fail |=> search_failed)
    else $error("failed state left");
  a_fail_idle: assert property (search_failed |-> !tracking) else $error("track while failed");
endmodule : mudl_phase_loop_chk
bind mudl_phase_loop mudl_phase_loop_chk #(.CODE_W(CODE_W), .PHASE_W(PHASE_W)) u_chk (.clk_sys, .arst_n,
  .loop_enable, .initial_code, .target_phase, .slope_negative, .guard_band, .restart_on_loss, .retry_on_fail,
  .measured_phase, .phase_valid, .phase_delay_code, .phase_loop_locked, .phase_loop_lost, .tracking,
  .search_failed);
`default_nettype wire

// ---- tb/mudl_phase_loop_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module mudl_phase_loop_tb_top;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic loop_enable = 1'b0, slope_negative = 1'b1, restart_on_loss = 1'b0, retry_on_fail = 1'b0;
  logic phase_valid = 1'b0;
  logic [8:0] initial_code = 9'h0d8, b;
  logic [4:0] target_phase = 5'h06, guard_band = 5'h0b, measured_phase = 5'h00, offs = 5'h00;
  logic [8:0] phase_delay_code;
  logic phase_loop_locked, phase_loop_lost, tracking, search_failed;
  wire [12:0] outs = {search_failed, tracking, phase_loop_lost, phase_loop_locked, phase_delay_code};
  int errors = 0, tests_run = 0;
  logic [8:0] exp_q[$];
  int sel_q[$];
  string nm[5] = '{"code", "locked", "lost", "tracking", "failed"};
  mudl_phase_loop dut (.clk_sys, .arst_n, .loop_enable, .initial_code, .target_phase, .slope_negative,
    .guard_band, .restart_on_loss, .retry_on_fail, .measured_phase, .phase_valid, .phase_delay_code,
    .phase_loop_locked, .phase_loop_lost, .tracking, .search_failed);
  // Free running system clock.
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic note(int s, logic [8:0] e);
    sel_q.push_back(s);
    exp_q.push_back(e);
  endtask : note
  // One detector sample, then a quiet cycle so the new code settles first.
  task automatic step;
    phase_valid <= 1'b1;
    @(posedge clk_sys);
    phase_valid <= 1'b0;
    @(posedge clk_sys);
  endtask : step
  // Detector with a falling phase as the code rises.
  task automatic det;
    measured_phase <= 5'(9'd222 - phase_delay_code) + offs;
    step;
  endtask : det
  task automatic start(logic [8:0] c);
    loop_enable <= 1'b0;
    initial_code <= c;
    repeat (2) @(posedge clk_sys);
    loop_enable <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : start
  task automatic close_out;
    @(negedge clk_sys);
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // Compares settled outputs against the oldest notes.
  initial begin : mon
    logic [8:0] e, g;
    int s;
    forever begin
      @(negedge clk_sys);
      while (sel_q.size() > 0) begin
        s = sel_q.pop_front();
        e = exp_q.pop_front();
        g = (s == 0) ? outs[8:0] : {8'h00, outs[8+s]};
        tests_run++;
        if (g !== e) begin
          errors++;
          $display("Error %s expected %0h seen %0h", nm[s], e, g);
        end
      end
    end
  end
  // Hang guard at 5000 cycles, far beyond the hundred or so cycles the tests need.
  initial begin
    #100us;
    errors++;
    close_out;
  end
  initial begin
    void'($urandom(88669));
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    note(0, 9'h0d8);
    b = 9'd100 + 9'($urandom_range(199));
    measured_phase <= 5'h16;
    start(b);
    note(0, b);
    step;
    note(0, b + 9'h001);
    step;
    note(0, b - 9'h001);
    step;
    note(0, b + 9'h002);
    // With no guard the sweep from code 1 reaches code 0 on its second sample.
    guard_band <= 5'h00;
    start(9'h001);
    repeat (2) step;
    note(4, 9'h001);
    note(0, 9'h000);
    repeat (3) step;
    note(4, 9'h001);
    note(3, 9'h000);
    guard_band <= 5'h0b;
    start(9'd218);
    for (int i = 0; i < 40 && tracking !== 1'b1; i++) det;
    note(3, 9'h001);
    note(1, 9'h001);
    note(0, 9'd216);
    // The offset is bench state read by det at once, so it is set by blocking assignment.
    offs = 5'h08;
    det;
    note(1, 9'h000);
    note(2, 9'h001);
    note(0, 9'd217);
    offs = 5'h00;
    det;
    note(1, 9'h001);
    note(2, 9'h000);
    note(0, 9'd216);
    det;
    note(1, 9'h001);
    note(0, 9'd216);
    // Loss with restart selected sends the loop back to a fresh search at the initial code.
    restart_on_loss <= 1'b1;
    offs = 5'h08;
    det;
    note(3, 9'h000);
    note(1, 9'h000);
    note(0, 9'd218);
    restart_on_loss <= 1'b0;
    offs = 5'h00;
    // A failed search with retry selected starts over at once from the initial code.
    retry_on_fail <= 1'b1;
    guard_band <= 5'h00;
    measured_phase <= 5'h16;
    start(9'h001);
    repeat (2) step;
    note(4, 9'h000);
    note(0, 9'h001);
    note(3, 9'h000);
    repeat (2) @(posedge clk_sys);
    close_out;
  end
endmodule : mudl_phase_loop_tb_top
`default_nettype wire
